// File: design/nvmpc_ctrl.v
/*
 Nonvolatile page program controller core: section decode, write rights,
 shared AND page buffer and page command sequencer.
 Assumes the core presents one store or load per cycle, counts instructions
 with i_instr_step, and that the array itself sits outside.
*/
`timescale 1ns/1ps
`include "nvmpc_defs.vh"
module nvmpc_ctrl
(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // Fuses and configuration
  input  wire [7:0]  i_boot_end_fuse,
  input  wire [7:0]  i_code_end_fuse,
  input  wire        i_vector_base_select,
  input  wire        i_wake,
  // Core side
  input  wire [15:0] i_exec_addr,
  input  wire        i_instr_step,
  input  wire        i_unlock,
  input  wire        i_cmd_wr,
  input  wire [2:0]  i_cmd,
  input  wire        i_lock_wr,
  input  wire        i_boot_read_lock,
  input  wire        i_code_section_write_guard,
  input  wire        i_store,
  input  wire        i_store_dbg,
  input  wire        i_store_is_ee,
  input  wire        i_store_is_user,
  input  wire        i_dev_locked,
  input  wire [15:0] i_store_addr,
  input  wire [7:0]  i_store_data,
  input  wire        i_load,
  input  wire [15:0] i_load_addr,
  input  wire [`NVMPC_PAGE_AW-1:0] i_buf_idx,
  // Status and array side
  output reg  [2:0]  o_cmd_field,
  output reg         o_boot_read_lock,
  output reg         o_code_section_write_guard,
  output reg         o_flash_busy_flag,
  output reg         o_eeprom_busy_flag,
  output wire        o_cpu_halt,
  output wire        o_bus_wait,
  output wire        o_load_blocked,
  output reg  [15:0] o_vector_base,
  output reg  [15:0] o_boot_top,
  output reg  [15:0] o_code_top,
  output reg         o_store_refused,
  output reg  [7:0]  o_buf_data,
  output reg         o_buf_mark,
  output reg  [15:0] o_page_addr,
  output reg         o_arr_erase,
  output reg         o_arr_write,
  output reg         o_arr_ee
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_ERASE = 3'b010;
  localparam ST_WRITE = 3'b100;
  reg [7:0]  buf_mem [0:`NVMPC_PAGE_BYTES-1];
  reg [`NVMPC_PAGE_BYTES-1:0] buf_marked;
  reg [2:0]  state;
  reg [15:0] op_cnt;
  reg [2:0]  unlock_cnt;
  reg        op_ee;
  reg        do_write;
  reg        in_boot;
  reg        in_code;
  reg        tgt_boot;
  reg        tgt_code;
  reg        allowed;
  reg [8:0]  boot_blk;
  reg [8:0]  code_blk;
  reg [15:0] boot_b;
  reg [15:0] code_b;
  integer    i;
  wire       any_marked = |buf_marked;
  wire       busy = (state != ST_IDLE);
  always @*
  begin
    boot_blk = {1'b0, i_boot_end_fuse};
    code_blk = {1'b0, i_code_end_fuse};
    if (boot_blk > `NVMPC_FLASH_BLOCKS)
      boot_blk = 9'h000;
    if (code_blk > `NVMPC_FLASH_BLOCKS)
      code_blk = 9'h000;
    if (boot_blk == 9'h000)
    begin
      boot_b = 16'h8000;
      code_b = 16'h8000;
    end
    else
    begin
      boot_b = {boot_blk[7:0], 8'h00};
      if (code_blk == 9'h000)
        code_b = 16'h8000;
      else if (code_blk <= boot_blk)
        code_b = boot_b;
      else
        code_b = {code_blk[7:0], 8'h00};
      if (boot_blk == `NVMPC_FLASH_BLOCKS)
        boot_b = 16'h8000;
    end
  end
  always @*
  begin
    in_boot  = (i_exec_addr < boot_b);
    in_code  = !in_boot && (i_exec_addr < code_b);
    tgt_boot = !i_store_is_ee && (i_store_addr < boot_b);
    tgt_code = !i_store_is_ee && !tgt_boot && (i_store_addr < code_b);
    if (i_store_dbg)
      allowed = i_store_is_user || !i_dev_locked;
    else if (tgt_boot)
      allowed = 1'b0;
    else if (tgt_code)
      allowed = in_boot && !o_code_section_write_guard;
    else
      allowed = in_boot || in_code;
  end
  assign o_load_blocked = o_boot_read_lock && !in_boot &&
                          (i_load_addr < boot_b);
  assign o_bus_wait = i_load && busy;
  assign o_cpu_halt = busy && !op_ee;
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_vector_base <= 16'h0000;
    else
      o_vector_base <= i_vector_base_select ? 16'h0000 : boot_b;
    o_boot_top <= boot_b;
    o_code_top <= code_b;
  end
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      unlock_cnt                 <= 3'h0;
      o_cmd_field                <= `NVMPC_CMD_NONE;
      o_boot_read_lock           <= 1'b0;
      o_code_section_write_guard <= 1'b0;
      o_store_refused            <= 1'b0;
      o_buf_data                 <= 8'h00;
      o_buf_mark                 <= 1'b0;
      state                      <= ST_IDLE;
      op_cnt                     <= 16'h0000;
      op_ee                      <= 1'b0;
      do_write                   <= 1'b0;
      o_page_addr                <= 16'h0000;
      o_arr_erase                <= 1'b0;
      o_arr_write                <= 1'b0;
      o_arr_ee                   <= 1'b0;
      o_flash_busy_flag          <= 1'b0;
      o_eeprom_busy_flag         <= 1'b0;
      buf_marked                 <= {`NVMPC_PAGE_BYTES{1'b0}};
      for (i = 0; i < `NVMPC_PAGE_BYTES; i = i + 1)
        buf_mem[i] <= `NVMPC_BUF_ONES;
    end
    else
    begin
      o_store_refused <= 1'b0;
      o_arr_erase     <= 1'b0;
      o_arr_write     <= 1'b0;
      o_buf_data      <= buf_mem[i_buf_idx];
      o_buf_mark      <= buf_marked[i_buf_idx];
      if (i_unlock)
        unlock_cnt <= `NVMPC_UNLOCK_WIN;
      else if (i_instr_step && unlock_cnt != 3'h0)
        unlock_cnt <= unlock_cnt - 3'h1;
      if (i_lock_wr)
      begin
        if (i_boot_read_lock && in_boot)
          o_boot_read_lock <= 1'b1;
        if (i_code_section_write_guard)
          o_code_section_write_guard <= 1'b1;
      end
      if (i_store && !busy)
      begin
        if (allowed)
        begin
          buf_mem[i_store_addr[`NVMPC_PAGE_AW-1:0]] <=
            buf_mem[i_store_addr[`NVMPC_PAGE_AW-1:0]] & i_store_data;
          buf_marked[i_store_addr[`NVMPC_PAGE_AW-1:0]] <= 1'b1;
          o_page_addr <= {i_store_addr[15:`NVMPC_PAGE_AW],
                          {`NVMPC_PAGE_AW{1'b0}}};
          op_ee <= i_store_is_ee || i_store_is_user;
        end
        else
          o_store_refused <= 1'b1;
      end
      case (state)
        ST_IDLE:
        begin
          if (i_cmd_wr && unlock_cnt != 3'h0)
          begin
            o_cmd_field <= i_cmd;
            unlock_cnt  <= 3'h0;
            op_cnt      <= `NVMPC_OP_CYCLES;
            if (i_cmd == `NVMPC_CMD_CLEAR || i_wake)
            begin
              buf_marked <= {`NVMPC_PAGE_BYTES{1'b0}};
              for (i = 0; i < `NVMPC_PAGE_BYTES; i = i + 1)
                buf_mem[i] <= `NVMPC_BUF_ONES;
            end
            else if (i_cmd == `NVMPC_CMD_WRITE)
            begin
              state       <= ST_WRITE;
              do_write    <= 1'b1;
              o_arr_write <= 1'b1;
              o_arr_ee    <= op_ee;
            end
            else if ((i_cmd == `NVMPC_CMD_ERASE ||
                      i_cmd == `NVMPC_CMD_ERWR) && any_marked)
            begin
              state       <= ST_ERASE;
              do_write    <= (i_cmd == `NVMPC_CMD_ERWR);
              o_arr_erase <= 1'b1;
              o_arr_ee    <= op_ee;
            end
          end
          else if (i_wake)
          begin
            buf_marked <= {`NVMPC_PAGE_BYTES{1'b0}};
            for (i = 0; i < `NVMPC_PAGE_BYTES; i = i + 1)
              buf_mem[i] <= `NVMPC_BUF_ONES;
          end
        end
        ST_ERASE:
        begin
          if (op_cnt == 16'h0001)
          begin
            op_cnt <= `NVMPC_OP_CYCLES;
            if (do_write)
            begin
              state       <= ST_WRITE;
              o_arr_write <= 1'b1;
            end
            else
              state <= ST_IDLE;
            if (!do_write)
            begin
              buf_marked <= {`NVMPC_PAGE_BYTES{1'b0}};
              for (i = 0; i < `NVMPC_PAGE_BYTES; i = i + 1)
                buf_mem[i] <= `NVMPC_BUF_ONES;
            end
          end
          else
            op_cnt <= op_cnt - 16'h0001;
        end
        ST_WRITE:
        begin
          if (op_cnt == 16'h0001)
          begin
            state      <= ST_IDLE;
            do_write   <= 1'b0;
            buf_marked <= {`NVMPC_PAGE_BYTES{1'b0}};
            for (i = 0; i < `NVMPC_PAGE_BYTES; i = i + 1)
              buf_mem[i] <= `NVMPC_BUF_ONES;
          end
          else
            op_cnt <= op_cnt - 16'h0001;
        end
        default:
          state <= ST_IDLE;
      endcase
      o_flash_busy_flag  <= (state != ST_IDLE) && !op_ee;
      o_eeprom_busy_flag <= (state != ST_IDLE) && op_ee;
    end
  end
endmodule

// File: design/nvmpc_defs.vh
/*
 Constants for the nonvolatile page program controller: section sizing,
 command codes, buffer geometry and timing counts.
 Assumes it is included by bare name from the design file.
*/
// Functional notes
// - Sections are sized in 256-byte blocks; boot spans zero to 256 times fuse.
// - Boot end fuse zero makes all Flash the boot section.
// - Code end zero, boot nonzero: code section runs to Flash top.
// - Code end at or below boot end: no code section, rest is data.
// - Code end above boot end: code between them, data above.
// - A fuse giving a boundary beyond Flash top falls back to default.
// - Vector table sits at code section start unless relocated to boot.
// - Boot writes code and data, code writes data, data writes nothing.
// - Boot read lock set only from boot; blocks boot access outside it.
// - Code section write guard refuses writes and erases to code section.
// - EEPROM pages change only in bytes marked by buffer stores.
// - User page skips chip erase, acts as EEPROM, debug writes when locked.
// - Array reads wait while a write or erase runs.
// - One shared page buffer, indexed by low store address bits.
// - Buffer stores AND new data into existing content.
// - Buffer goes all ones on reset, operation end, clear, wake.
// - Flash is programmed and erased only as whole pages.
// - Combined erase-write plus separate erase and write commands exist.
// - Page write copies buffer; Flash stalls core, EEPROM does not.
// - Page erase needs one written byte; Flash erases whole page, halted.
// - EEPROM page erase clears only written bytes, core keeps running.
// - Command is a three-bit field in low bits of control one.
// - Busy flags read one while their array is busy.
`ifndef NVMPC_DEFS_VH
`define NVMPC_DEFS_VH
`define NVMPC_BLOCK_SHIFT   8
`define NVMPC_FLASH_AW      15
`define NVMPC_FLASH_BLOCKS  9'h080
`define NVMPC_PAGE_BYTES    64
`define NVMPC_PAGE_AW       6
`define NVMPC_BUF_ONES      8'hff
`define NVMPC_CMD_NONE      3'h0
`define NVMPC_CMD_WRITE     3'h1
`define NVMPC_CMD_ERASE     3'h2
`define NVMPC_CMD_ERWR      3'h3
`define NVMPC_CMD_CLEAR     3'h4
`define NVMPC_UNLOCK_WIN    3'h4
`define NVMPC_OP_CYCLES     16'h0100
`endif

// File: verification/nvmpc_ctrl_sva.sv
/*
 Concurrent checks on the page program controller ports.
 Assumes it is bound to nvmpc_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module nvmpc_ctrl_sva (
  // Clock and reset
  input wire        i_clk,
  input wire        i_sys_rst,
  // Watched inputs
  input wire [7:0]  i_boot_end_fuse,
  input wire        i_vector_base_select,
  input wire [15:0] i_exec_addr,
  input wire        i_cmd_wr,
  input wire        i_lock_wr,
  input wire        i_boot_read_lock,
  input wire        i_code_section_write_guard,
  input wire        i_load,
  input wire [15:0] i_load_addr,
  // Watched outputs
  input wire [2:0]  o_cmd_field,
  input wire        o_boot_read_lock,
  input wire        o_code_section_write_guard,
  input wire        o_flash_busy_flag,
  input wire        o_eeprom_busy_flag,
  input wire        o_cpu_halt,
  input wire        o_bus_wait,
  input wire        o_load_blocked,
  input wire [15:0] o_vector_base,
  input wire [15:0] o_boot_top,
  input wire        o_arr_write
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_start;
    o_arr_write;
  endsequence
  sequence s_busy;
    o_flash_busy_flag || o_eeprom_busy_flag;
  endsequence
  property p_wait;
    i_load && (o_flash_busy_flag || o_eeprom_busy_flag) |-> o_bus_wait;
  endproperty
  a_wait: assert property (p_wait) else $error("load not stalled");
  property p_busy;
    s_start |=> s_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag late");
  property p_cmd;
    !$past(i_cmd_wr) && !$past(i_sys_rst) |-> $stable(o_cmd_field);
  endproperty
  a_cmd: assert property (p_cmd) else $error("field moved");
  property p_ee_run;
    o_eeprom_busy_flag && !o_flash_busy_flag |-> !o_cpu_halt;
  endproperty
  a_ee_run: assert property (p_ee_run) else $error("core halted");
  property p_blk;
    i_load && o_boot_read_lock && i_exec_addr >= o_boot_top
      && i_load_addr < o_boot_top |-> o_load_blocked;
  endproperty
  a_blk: assert property (p_blk) else $error("boot read open");
  property p_lock;
    $rose(o_boot_read_lock) |->
      $past(i_lock_wr && i_boot_read_lock && i_exec_addr < o_boot_top);
  endproperty
  a_lock: assert property (p_lock) else $error("lock set wrongly");
  property p_guard;
    $rose(o_code_section_write_guard) |->
      $past(i_lock_wr && i_code_section_write_guard);
  endproperty
  a_guard: assert property (p_guard) else $error("guard set");
  property p_vec;
    i_vector_base_select |=> o_vector_base == 16'h0000;
  endproperty
  a_vec: assert property (p_vec) else $error("vector base");
  property p_top;
    !$past(i_sys_rst) && $past(i_boot_end_fuse) != 8'h00
      && $past(i_boot_end_fuse) < 8'h80
      |-> o_boot_top == {$past(i_boot_end_fuse), 8'h00};
  endproperty
  a_top: assert property (p_top) else $error("boot top");
  property p_all;
    !$past(i_sys_rst) && $past(i_boot_end_fuse) == 8'h00
      |-> o_boot_top == 16'h8000;
  endproperty
  a_all: assert property (p_all) else $error("boot not whole");
endmodule
bind nvmpc_ctrl nvmpc_ctrl_sva nvmpc_ctrl_sva_inst (.*);

// File: verification/nvmpc_core_model.sv
/*
 Core model that issues unlocked commands to the controller.
 Assumes issue is called at a falling clock edge.
*/
`timescale 1ns/1ps
module nvmpc_core_model (
  // Clock and status
  input  wire       i_clk,
  input  wire       i_flash_busy,
  input  wire       i_ee_busy,
  // Command side
  output reg        o_unlock,
  output reg        o_step,
  output reg        o_cmd_wr,
  output reg  [2:0] o_cmd
);
  initial
  begin
    o_unlock = 1'b0;
    o_step = 1'b0;
    o_cmd_wr = 1'b0;
    o_cmd = 3'h0;
  end
  task issue(input [2:0] c, input integer gap);
    integer n;
    begin
      while (i_flash_busy || i_ee_busy)
        @(negedge i_clk);
      o_unlock = 1'b1;
      @(negedge i_clk);
      o_unlock = 1'b0;
      for (n = 0; n < gap; n = n + 1)
      begin
        o_step = 1'b1;
        @(negedge i_clk);
        o_step = 1'b0;
      end
      o_cmd = c;
      o_cmd_wr = 1'b1;
      @(negedge i_clk);
      o_cmd_wr = 1'b0;
      o_cmd = ~c;
    end
  endtask
endmodule

// File: verification/test_nvm_page_program_ctrl.sv
/*
 Self-checking bench for nvmpc_ctrl driven through a core model.
 Assumes the checker is bound and the model sits beside the design.
*/
`timescale 1ns/1ps
module test_nvm_page_program_ctrl;
  reg i_clk, i_sys_rst, i_vector_base_select, i_wake, i_lock_wr;
  reg i_boot_read_lock, i_code_section_write_guard, i_store, i_store_dbg;
  reg i_store_is_ee, i_store_is_user, i_dev_locked, i_load;
  reg [7:0] i_boot_end_fuse, i_code_end_fuse, i_store_data;
  reg [15:0] i_exec_addr, i_store_addr, i_load_addr;
  reg [5:0] i_buf_idx;
  reg [47:0] ft [0:4];
  wire i_unlock, i_instr_step, i_cmd_wr, o_boot_read_lock, o_cpu_halt;
  wire o_code_section_write_guard, o_flash_busy_flag, o_eeprom_busy_flag;
  wire o_bus_wait, o_load_blocked, o_store_refused, o_buf_mark;
  wire o_arr_erase, o_arr_write, o_arr_ee;
  wire [2:0] i_cmd, o_cmd_field;
  wire [7:0] o_buf_data;
  wire [15:0] o_vector_base, o_boot_top, o_code_top, o_page_addr;
  integer errors, n_compared, k, w;
  nvmpc_ctrl nvmpc_ctrl_inst (.*);
  nvmpc_core_model nvmpc_core_model_inst (.i_clk(i_clk),
    .i_flash_busy(o_flash_busy_flag), .i_ee_busy(o_eeprom_busy_flag),
    .o_unlock(i_unlock), .o_step(i_instr_step), .o_cmd_wr(i_cmd_wr),
    .o_cmd(i_cmd));
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task chk(input [15:0] g, input [15:0] e);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("FAIL t=%0t got %h want %h", $time, g, e);
    end
  end
  endtask
  task st(input [15:0] a, input [7:0] d, input e);
  begin
    i_store_addr = a;
    i_store_data = d;
    i_store_is_ee = e;
    i_store = 1'b1;
    @(negedge i_clk);
    i_store = 1'b0;
  end
  endtask
  task pk(input [5:0] a, input [7:0] e);
  begin
    i_buf_idx = a;
    @(negedge i_clk);
    chk(o_buf_data, e);
  end
  endtask
  task lk(input b, input g);
  begin
    i_boot_read_lock = b;
    i_code_section_write_guard = g;
    i_lock_wr = 1'b1;
    @(negedge i_clk);
    i_lock_wr = 1'b0;
  end
  endtask
  task idle;
  begin
    w = 0;
    @(negedge i_clk);
    while ((o_flash_busy_flag || o_eeprom_busy_flag) && w < 800)
    begin
      @(negedge i_clk);
      w = w + 1;
    end
    chk(o_flash_busy_flag | o_eeprom_busy_flag, 0);
  end
  endtask
  task ld(input [15:0] a, input x);
  begin
    i_load_addr = a;
    i_load = 1'b1;
    #1 chk(x ? o_load_blocked : o_bus_wait, 1);
    @(negedge i_clk);
    i_load = 1'b0;
  end
  endtask
  task summarize;
  begin
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  initial
  begin
    repeat (20000) @(posedge i_clk);
    errors = errors + 1;
    summarize;
  end
  initial
  begin
    errors = 0;
    n_compared = 0;
    {i_vector_base_select, i_wake, i_lock_wr, i_boot_read_lock, i_load,
     i_code_section_write_guard, i_store, i_store_dbg, i_store_is_ee,
     i_store_is_user, i_dev_locked, i_store_data, i_exec_addr,
     i_store_addr, i_load_addr, i_buf_idx} = '0;
    {i_boot_end_fuse, i_code_end_fuse} = 16'h0408;
    ft[0] = 48'h0408_0400_0800;
    ft[1] = 48'h0400_0400_8000;
    ft[2] = 48'h0402_0400_0400;
    ft[3] = 48'h0000_8000_8000;
    ft[4] = 48'h9000_8000_8000;
    i_sys_rst = 1'b1;
    repeat (8) @(posedge i_clk);
    @(negedge i_clk) i_sys_rst = 1'b0;
    pk(6'h00, 8'hff);
    $display("test reset done");
    for (k = 0; k < 5; k = k + 1)
    begin
      {i_boot_end_fuse, i_code_end_fuse} = ft[k][47:32];
      repeat (2) @(negedge i_clk);
      chk(o_boot_top, ft[k][31:16]);
      chk(o_code_top, ft[k][15:0]);
    end
    {i_boot_end_fuse, i_code_end_fuse} = 16'h0408;
    repeat (2) @(negedge i_clk);
    chk(o_vector_base, 16'h0400);
    i_vector_base_select = 1'b1;
    repeat (2) @(negedge i_clk);
    chk(o_vector_base, 16'h0000);
    i_vector_base_select = 1'b0;
    $display("test sections done");
    st(16'h0805, 8'hf0, 0);
    st(16'h0805, 8'h3c, 0);
    pk(6'h05, 8'h30);
    chk(o_buf_mark, 1);
    chk(o_page_addr, 16'h0800);
    nvmpc_core_model_inst.issue(3'h1, 5);
    @(negedge i_clk);
    chk(o_cmd_field, 3'h0);
    nvmpc_core_model_inst.issue(3'h1, 1);
    chk(o_arr_write, 1);
    chk(o_cpu_halt, 1);
    @(negedge i_clk);
    chk(o_flash_busy_flag, 1);
    ld(16'h0000, 0);
    idle;
    chk(w < 300, 1);
    pk(6'h05, 8'hff);
    $display("test write done");
    nvmpc_core_model_inst.issue(3'h2, 1);
    chk(o_arr_erase, 0);
    st(16'h1403, 8'h00, 1);
    nvmpc_core_model_inst.issue(3'h2, 1);
    chk(o_arr_erase & o_arr_ee & ~o_cpu_halt, 1);
    idle;
    st(16'h0900, 8'h00, 0);
    nvmpc_core_model_inst.issue(3'h3, 1);
    chk(o_arr_erase, 1);
    idle;
    chk(w > 400, 1);
    $display("test erase done");
    i_exec_addr = 16'h0900;
    st(16'h1400, 8'h00, 1);
    chk(o_store_refused, 1);
    i_exec_addr = 16'h0400;
    st(16'h0500, 8'h00, 0);
    chk(o_store_refused, 1);
    st(16'h0a00, 8'h00, 0);
    chk(o_store_refused, 0);
    i_exec_addr = 16'h0000;
    lk(0, 1);
    st(16'h0500, 8'h00, 0);
    chk(o_store_refused, 1);
    i_exec_addr = 16'h0400;
    lk(1, 0);
    chk(o_boot_read_lock, 0);
    i_exec_addr = 16'h0000;
    lk(1, 0);
    i_exec_addr = 16'h0400;
    ld(16'h0010, 1);
    i_store_dbg = 1'b1;
    i_dev_locked = 1'b1;
    st(16'h1401, 8'h5a, 1);
    chk(o_store_refused, 1);
    i_store_is_user = 1'b1;
    st(16'h1401, 8'h5a, 1);
    chk(o_store_refused, 0);
    pk(6'h01, 8'h5a);
    i_store_dbg = 1'b0;
    i_dev_locked = 1'b0;
    i_store_is_user = 1'b0;
    i_wake = 1'b1;
    @(negedge i_clk);
    i_wake = 1'b0;
    pk(6'h01, 8'hff);
    st(16'h1402, 8'h11, 1);
    pk(6'h02, 8'h11);
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_sys_rst = 1'b0;
    pk(6'h02, 8'hff);
    chk(o_boot_read_lock, 0);
    $display("test protect done");
    summarize;
  end
endmodule
